// [core/rpb_reset_pin_boot_sequencer.sv]
// reset pin sequencing, option image, boot source and vector remap
//
// Function
// - drive pin low 128 clocks and flash done
// - release pin, end reset after pin high
// - external low pin holds chip reset
// - option bit 3 clear disables pin until power-on
// - flash boot: stack 0x0, start 0x4
// - rom boot remaps vector fetches to rom
// - cleared mode register ends rom remap
// - boot source settled before core release
// - rom boot blocks nonmaskable interrupt
// - mode bits override, cleared by one
// - option image read-only, from option byte
// - new option takes effect next reset
// - option byte zero loads all ones
// - option bit 5 selects flash init speed
// - pin enable kept through system resets
// - disabled pin gives no wakeup
// - enabled pin: open drain, pullup, filter
// - factory trim autoloaded during boot
// - low-power boot sets clock divider reset
// - source from bits 7:6 unless pin forces
`timescale 1ns/1ps
`default_nettype none

module rpb_reset_pin_boot_sequencer #(
  parameter int HOLD_CLKS = rpb_pkg::MIN_HOLD_CLKS
) (
  // clock and power-on reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // reset sources, same clock domain
  input  wire logic        sysResetReq,
  input  wire logic        vllsWakeup,
  input  wire logic        vllsWakeupViaPin,
  // nonvolatile option byte and factory trim
  input  wire logic [7:0]  optionByte,
  input  wire logic [7:0]  factoryTrim,
  // flash controller
  input  wire logic        flashInitDone,
  output logic             flashResetN,
  output logic             flashFastInit,
  // open-drain reset pin
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOe,
  output logic             resetPinPullupEn,
  output logic             resetPinFilterEn,
  output logic             resetPinOpenDrain,
  output logic             resetPinWakeupEn,
  // boot select and interrupt pin, active low
  input  wire logic        bootPinInN,
  output logic             nmiToCore,
  // core side
  output logic             chipResetN,
  output logic [2:0]       coreClockDivider,
  output logic             lowPowerRun,
  input  wire logic [31:0] vecFetchAddr,
  output logic [31:0]      vecFetchAddrOut,
  output logic             vectorRemap,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // refuse hold counts the 16-bit counter cannot serve
  if (HOLD_CLKS < 1 || HOLD_CLKS > 65535) begin : g_holdCheck
    $error("HOLD_CLKS out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic pinMeta_q;
  logic pinSync_q;
  logic bootMeta_q;
  logic bootSync_q;

  // two flops per pin input
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_q  <= 1'b1;
      pinSync_q  <= 1'b1;
      bootMeta_q <= 1'b1;
      bootSync_q <= 1'b1;
    end else begin
      pinMeta_q  <= resetPinIn;
      pinSync_q  <= pinMeta_q;
      bootMeta_q <= bootPinInN;
      bootSync_q <= bootMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  rpb_pkg::rpb_state_t state_q;
  rpb_pkg::rpb_state_t state_d;
  logic [15:0] holdCnt_q;
  logic        optLoaded_q;
  logic        porSeq_q;
  logic        noPinSeq_q;
  logic        pinEnable_q;
  logic [7:0]  optImage_q;
  logic [7:0]  trim_q;
  logic [2:0]  divider_q;
  logic        lpRun_q;
  logic [2:1]  fm_q;
  logic [2:1]  fmLatched_q;
  logic [2:1]  mr_q;

  // reset source decode
  wire pinReset    = pinEnable_q && !pinSync_q;
  wire startReset  = (state_q == rpb_pkg::ST_RUN) &&
                     (sysResetReq || vllsWakeup || pinReset);
  wire startNoPin  = vllsWakeup && !vllsWakeupViaPin && !sysResetReq && !pinReset;
  wire holdDone    = holdCnt_q >= 16'(HOLD_CLKS);
  wire flashDone   = optLoaded_q && flashInitDone;
  wire pinIsHigh   = !pinEnable_q || pinSync_q;
  wire [7:0] optFixed = (optionByte == rpb_pkg::OPT_INVALID) ?
                        rpb_pkg::OPT_ERASED : optionByte;

  // state transitions
  always_comb begin
    state_d = state_q;
    case (state_q)
      rpb_pkg::ST_HOLD: begin
        if (holdDone && flashDone && !sysResetReq) begin
          state_d = rpb_pkg::ST_RELEASE;
        end
      end
      rpb_pkg::ST_RELEASE: begin
        if (pinIsHigh) begin
          state_d = rpb_pkg::ST_SETTLE;
        end
      end
      rpb_pkg::ST_SETTLE: begin
        state_d = rpb_pkg::ST_RUN;
      end
      rpb_pkg::ST_RUN: begin
        if (startReset) begin
          state_d = rpb_pkg::ST_HOLD;
        end
      end
      default: begin
        state_d = rpb_pkg::ST_HOLD;
      end
    endcase
  end

  // state, counter and sequence flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q     <= rpb_pkg::ST_HOLD;
      holdCnt_q   <= 16'h0000;
      porSeq_q    <= 1'b1;
      noPinSeq_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (startReset) begin
        holdCnt_q  <= 16'h0000;
        porSeq_q   <= 1'b0;
        noPinSeq_q <= startNoPin;
      end else if (state_q == rpb_pkg::ST_HOLD && !holdDone) begin
        holdCnt_q <= holdCnt_q + 16'h0001;
      end
    end
  end

  // divider reset value from the low-power boot code
  wire [1:0] lpCode = {optFixed[rpb_pkg::BIT_LOW_POWER_BOOT_DIVIDER_HI], optFixed[rpb_pkg::BIT_LOW_POWER_BOOT_DIVIDER_LO]};
  wire [2:0] lpDivider = (lpCode == 2'h0) ? rpb_pkg::DIV_LP00 :
                         (lpCode == 2'h1) ? rpb_pkg::DIV_LP01 :
                         (lpCode == 2'h2) ? rpb_pkg::DIV_LP10 : rpb_pkg::DIV_LP11;

  // option image, divider and trim load at start of each sequence
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      optLoaded_q <= 1'b0;
      optImage_q  <= rpb_pkg::OPT_ERASED;
      pinEnable_q <= 1'b1;
      trim_q      <= 8'h00;
      divider_q   <= rpb_pkg::DIV_LP11;
      lpRun_q     <= 1'b0;
    end else if (startReset) begin
      optLoaded_q <= 1'b0;
    end else if (state_q == rpb_pkg::ST_HOLD && !optLoaded_q) begin
      optLoaded_q <= 1'b1;
      optImage_q  <= optFixed;
      trim_q      <= factoryTrim;
      if (porSeq_q) begin
        pinEnable_q <= optFixed[rpb_pkg::BIT_PIN_EN];
      end
      divider_q <= lpDivider;
      lpRun_q   <= !optFixed[rpb_pkg::BIT_LOW_POWER_BOOT_DIVIDER_HI];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot source decision

  wire srcRom   = optImage_q[rpb_pkg::BIT_SRC_HI:rpb_pkg::BIT_SRC_LO] == rpb_pkg::SRC_ROM;
  wire romByOpt = srcRom || (fmLatched_q != 2'h0);
  wire romByPin = !optImage_q[rpb_pkg::BIT_BOOTPIN_OPT] && !bootSync_q;
  wire settle   = (state_q == rpb_pkg::ST_RELEASE) && pinIsHigh;

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic        awHave_q;
  logic        wHave_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // write handshake and decode
  wire awFire  = s_axi_awvalid && s_axi_awready;
  wire wFire   = s_axi_wvalid && s_axi_wready;
  wire wrDo    = awHave_q && wHave_q && !bvalid_q;
  wire wrFm    = wrDo && awAddr_q == rpb_pkg::OFF_FORCED_MODE && wStrb_q[0];
  wire wrMr    = wrDo && awAddr_q == rpb_pkg::OFF_BOOT_MODE && wStrb_q[0];
  wire wrKnown = awAddr_q == rpb_pkg::OFF_OPTION_IMAGE || awAddr_q == rpb_pkg::OFF_FORCED_MODE ||
                 awAddr_q == rpb_pkg::OFF_BOOT_MODE || awAddr_q == rpb_pkg::OFF_STATUS ||
                 awAddr_q == rpb_pkg::OFF_TRIM;
  wire [2:1] mrClr = wrMr ? wData_q[2:1] : 2'h0;
  wire [2:1] mrSet = settle ? {romByOpt, romByPin} : 2'h0;

  // read decode
  wire arFire = s_axi_arvalid && s_axi_arready;
  wire [31:0] statusWord = {24'h0, lpRun_q, divider_q, pinEnable_q,
                            vectorRemap, chipResetN, flashFastInit};
  wire rdKnown = s_axi_araddr == rpb_pkg::OFF_OPTION_IMAGE ||
                 s_axi_araddr == rpb_pkg::OFF_FORCED_MODE ||
                 s_axi_araddr == rpb_pkg::OFF_BOOT_MODE ||
                 s_axi_araddr == rpb_pkg::OFF_STATUS || s_axi_araddr == rpb_pkg::OFF_TRIM;
  wire [31:0] rdMux =
      (s_axi_araddr == rpb_pkg::OFF_OPTION_IMAGE) ? {24'h0, optImage_q} :
      (s_axi_araddr == rpb_pkg::OFF_FORCED_MODE)  ? {29'h0, fm_q, 1'b0} :
      (s_axi_araddr == rpb_pkg::OFF_BOOT_MODE)    ? {29'h0, mr_q, 1'b0} :
      (s_axi_araddr == rpb_pkg::OFF_STATUS)       ? statusWord :
      (s_axi_araddr == rpb_pkg::OFF_TRIM)         ? {24'h0, trim_q} : 32'h0;

  // write address and data capture, either order
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
    end else begin
      if (awFire) begin
        awHave_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end else if (wrDo) begin
        awHave_q <= 1'b0;
      end
      if (wFire) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (wrDo) begin
        wHave_q <= 1'b0;
      end
    end
  end

  // write and read responses
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= rpb_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= rpb_pkg::RESP_OKAY;
      rdata_q  <= 32'h0;
    end else begin
      if (wrDo) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wrKnown ? rpb_pkg::RESP_OKAY : rpb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (arFire) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rdKnown ? rpb_pkg::RESP_OKAY : rpb_pkg::RESP_SLVERR;
        rdata_q  <= rdMux;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // forced mode: applies to the next sequence, then clears
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fm_q        <= 2'h0;
      fmLatched_q <= 2'h0;
    end else if (startReset) begin
      fmLatched_q <= fm_q;
      fm_q        <= 2'h0;
    end else if (wrFm) begin
      fm_q <= wData_q[2:1];
    end
  end

  // boot mode: set on entry to settle, write one to clear, set wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mr_q <= 2'h0;
    end else if (startReset) begin
      mr_q <= 2'h0;
    end else begin
      mr_q <= (mr_q & ~mrClr) | mrSet;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // bus handshakes
  assign s_axi_awready = !awHave_q && !bvalid_q;
  assign s_axi_wready  = !wHave_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // reset pin: open drain, driven low during the hold phase
  assign resetPinOut       = 1'b0;
  assign resetPinOe        = (state_q == rpb_pkg::ST_HOLD) && pinEnable_q &&
                             !noPinSeq_q;
  assign resetPinPullupEn  = pinEnable_q;
  assign resetPinFilterEn  = pinEnable_q;
  assign resetPinOpenDrain = pinEnable_q;
  assign resetPinWakeupEn  = pinEnable_q;

  // flash and chip reset
  assign flashResetN   = (state_q != rpb_pkg::ST_HOLD) || optLoaded_q;
  assign flashFastInit = optImage_q[rpb_pkg::BIT_FAST_INIT];
  assign chipResetN    = state_q == rpb_pkg::ST_RUN;

  // clock divider reset values
  assign coreClockDivider = divider_q;
  assign lowPowerRun      = lpRun_q;

  // vector fetch remap
  assign vectorRemap     = mr_q != 2'h0;
  assign vecFetchAddrOut = vectorRemap ? (rpb_pkg::ROM_BASE | vecFetchAddr) :
                           (rpb_pkg::FLASH_BASE | vecFetchAddr);

  // interrupt gate
  assign nmiToCore = !bootSync_q && optImage_q[rpb_pkg::BIT_NMI_EN] &&
                     !vectorRemap && chipResetN;

endmodule

`default_nettype wire

// [inc/rpb_pkg.sv]
// constants for the reset pin and boot sequencer
package rpb_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_OPTION_IMAGE = 8'h00;
  localparam logic [7:0] OFF_FORCED_MODE  = 8'h04;
  localparam logic [7:0] OFF_BOOT_MODE    = 8'h08;
  localparam logic [7:0] OFF_STATUS       = 8'h0c;
  localparam logic [7:0] OFF_TRIM         = 8'h10;
  // option image field positions
  localparam int BIT_BOOTPIN_OPT = 1;
  localparam int BIT_NMI_EN      = 2;
  localparam int BIT_PIN_EN      = 3;
  localparam int BIT_LOW_POWER_BOOT_DIVIDER_LO   = 0;
  localparam int BIT_LOW_POWER_BOOT_DIVIDER_HI   = 4;
  localparam int BIT_FAST_INIT   = 5;
  localparam int BIT_SRC_LO      = 6;
  localparam int BIT_SRC_HI      = 7;
  // option image values
  localparam logic [7:0] OPT_INVALID = 8'h00;
  localparam logic [7:0] OPT_ERASED  = 8'hff;
  localparam logic [1:0] SRC_ROM     = 2'h3;
  // mode register field positions
  localparam int BIT_MODE_PIN = 1;
  localparam int BIT_MODE_OPT = 2;
  // vector addresses
  localparam logic [31:0] ROM_BASE   = 32'h1c00_0000;
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] VEC_SP     = 32'h0000_0000;
  localparam logic [31:0] VEC_PC     = 32'h0000_0004;
  // least pin hold time, in bus clocks
  localparam int MIN_HOLD_CLKS = 128;
  // divider reset values per low-power boot code
  localparam logic [2:0] DIV_LP00 = 3'h7;
  localparam logic [2:0] DIV_LP01 = 3'h3;
  localparam logic [2:0] DIV_LP10 = 3'h1;
  localparam logic [2:0] DIV_LP11 = 3'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states
  typedef enum logic [3:0] {
    ST_HOLD    = 4'h1,
    ST_RELEASE = 4'h2,
    ST_SETTLE  = 4'h4,
    ST_RUN     = 4'h8
  } rpb_state_t;
endpackage

// [tb/rpb_pin_model.sv]
// outside reset circuitry on the open-drain reset pin
`timescale 1ns/1ps
`default_nettype none

module rpb_pin_model (
  // pin drivers
  input  wire logic driveLow,
  input  wire logic extHold,
  // resolved pin level
  output logic      pinLevel
);
  // open drain with pull-up: low if any party pulls
  assign pinLevel = !(driveLow || extHold);
endmodule

`default_nettype wire

// [tb/rpb_seq_sva.sv]
// assertions on the sequencer ports
`timescale 1ns/1ps
`default_nettype none

module rpb_seq_sva #(
  parameter int HOLD_CLKS = 128
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // pin and flash
  input wire logic        flashInitDone,
  input wire logic        resetPinIn,
  input wire logic        resetPinOut,
  input wire logic        resetPinOe,
  input wire logic        resetPinPullupEn,
  input wire logic        resetPinFilterEn,
  input wire logic        resetPinOpenDrain,
  input wire logic        resetPinWakeupEn,
  // core side
  input wire logic        nmiToCore,
  input wire logic        chipResetN,
  input wire logic [2:0]  coreClockDivider,
  input wire logic        lowPowerRun,
  input wire logic [31:0] vecFetchAddr,
  input wire logic [31:0] vecFetchAddrOut,
  input wire logic        vectorRemap
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // pin drive length and seen-run flag
  logic [15:0] oeCnt_q;
  logic        ranOnce_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      oeCnt_q   <= 16'h0;
      ranOnce_q <= 1'b0;
    end else begin
      oeCnt_q   <= resetPinOe ? oeCnt_q + 16'h1 : 16'h0;
      ranOnce_q <= ranOnce_q | chipResetN;
    end
  end

  a_hold_min: assert property (
    $fell(resetPinOe) && resetPinPullupEn |-> oeCnt_q >= HOLD_CLKS && $past(flashInitDone))
    else $error("pin released early");
  a_pin_high: assert property (
    $rose(chipResetN) && resetPinPullupEn |-> $past(resetPinIn) && $past(resetPinIn, 2)
    && !resetPinOe) else $error("reset ended before pin high");
  a_ext_low: assert property (
    (resetPinPullupEn && !chipResetN && !resetPinIn) [*4] |=> !chipResetN)
    else $error("reset ended with pin held low");
  a_flash_vec: assert property (
    !vectorRemap |-> vecFetchAddrOut == vecFetchAddr) else $error("flash vector wrong");
  a_rom_vec: assert property (
    vectorRemap |-> vecFetchAddrOut == (rpb_pkg::ROM_BASE | vecFetchAddr))
    else $error("rom vector wrong");
  a_src_settled: assert property (
    $rose(chipResetN) |-> $stable(vectorRemap)) else $error("boot source late");
  a_nmi_block: assert property (
    vectorRemap |-> !nmiToCore) else $error("nmi passed in rom boot");
  a_no_wake: assert property (
    !resetPinPullupEn |-> !resetPinWakeupEn && !resetPinOe) else $error("disabled pin active");
  a_pin_kept: assert property (
    ranOnce_q |-> $stable(resetPinPullupEn)) else $error("pin enable changed");
  a_pin_attrs: assert property (
    resetPinOpenDrain == resetPinPullupEn && resetPinFilterEn == resetPinPullupEn
    && !resetPinOut) else $error("pin attributes wrong");
  a_div_map: assert property (
    chipResetN |-> coreClockDivider inside {3'h7, 3'h3, 3'h1, 3'h0}
    && lowPowerRun == coreClockDivider[1]) else $error("divider map wrong");
endmodule

bind rpb_reset_pin_boot_sequencer rpb_seq_sva #(.HOLD_CLKS(HOLD_CLKS)) i_sva (
  .core_clk, .nrst, .flashInitDone, .resetPinIn, .resetPinOut, .resetPinOe,
  .resetPinPullupEn, .resetPinFilterEn, .resetPinOpenDrain, .resetPinWakeupEn,
  .nmiToCore, .chipResetN, .coreClockDivider, .lowPowerRun, .vecFetchAddr,
  .vecFetchAddrOut, .vectorRemap);

`default_nettype wire

// [tb/tb_reset_pin_boot_sequencer.sv]
// testbench for the reset pin and boot sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_reset_pin_boot_sequencer;
  localparam int HOLD = 8;
  localparam logic [7:0] TBL [5] = '{8'h00, 8'h28, 8'h09, 8'h18, 8'h01};
  // design inputs and bench state
  logic        core_clk, nrst, sysResetReq, vllsWakeup, vllsWakeupViaPin, flashInitDone;
  logic        bootPinInN, extHold, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic [7:0]  optionByte, factoryTrim, s_axi_awaddr, s_axi_araddr;
  logic [31:0] vecFetchAddr, s_axi_wdata;
  logic [31:0] rs = 32'h13bf;
  int          mismatches, checks, oeCnt;
  // design outputs
  logic        resetPinIn, resetPinOe, chipResetN, vectorRemap, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, flashResetN;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] vecFetchAddrOut, s_axi_rdata;

  rpb_reset_pin_boot_sequencer #(.HOLD_CLKS(HOLD)) i_dut (
    .core_clk, .nrst, .sysResetReq, .vllsWakeup, .vllsWakeupViaPin, .optionByte,
    .factoryTrim, .flashInitDone, .flashResetN, .flashFastInit(), .resetPinIn,
    .resetPinOut(), .resetPinOe, .resetPinPullupEn(), .resetPinFilterEn(),
    .resetPinOpenDrain(), .resetPinWakeupEn(), .bootPinInN, .nmiToCore(), .chipResetN,
    .coreClockDivider(), .lowPowerRun(), .vecFetchAddr, .vecFetchAddrOut, .vectorRemap,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready(1'b1));
  rpb_pin_model i_pin (.driveLow(resetPinOe), .extHold, .pinLevel(resetPinIn));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // status word: lpr, divider, pin enable, remap, run, fast init
  function automatic logic [31:0] expStat(input logic [7:0] o, input logic pe, input logic rom);
    logic [2:0] dv;
    case ({o[4], o[0]})
      2'b00: dv = 3'h7;
      2'b01: dv = 3'h3;
      2'b10: dv = 3'h1;
      default: dv = 3'h0;
    endcase
    return {24'h0, ~o[4], dv, pe, rom, 1'b1, o[5]};
  endfunction

  ////////////////////////////////////////////////////////////
  // clock, random fetch addresses, drive watcher
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    rs <= lfsr(rs);
    vecFetchAddr <= rs & 32'h0000_00fc;
    if (resetPinOe) oeCnt <= oeCnt + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b) begin
      @(negedge core_clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    v = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!v) begin
      @(negedge core_clk);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    chk(d, e);
    chk(r, er);
  endtask

  task automatic waitRun();
    repeat (300) if (chipResetN !== 1'b1) @(posedge core_clk);
    @(negedge core_clk);
    chk(chipResetN, 1'b1);
    @(posedge core_clk);
  endtask

  // outside party holds pin past flash init, then lets go
  task automatic bootSeq(input logic pe);
    flashInitDone <= 1'b0;
    extHold <= 1'b1;
    repeat (HOLD + 6) @(posedge core_clk);
    flashInitDone <= 1'b1;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    chk(chipResetN, !pe);
    chk(flashResetN, 1'b1);
    @(posedge core_clk);
    extHold <= 1'b0;
    waitRun();
  endtask

  task automatic powerOn(input logic [7:0] o, input logic bp, input logic pe);
    optionByte <= o;
    bootPinInN <= bp;
    factoryTrim <= rs[15:8];
    nrst <= 1'b0;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    chk(flashResetN, 1'b0);
    @(posedge core_clk);
    nrst <= 1'b1;
    bootSeq(pe);
  endtask

  // register contents, vector path, then clear the mode bits
  task automatic checkBoot(input logic [7:0] eo, input logic pe, input logic rom);
    logic [1:0] r;
    rdChk(8'h00, {24'h0, eo}, 2'h0);
    rdChk(8'h0c, expStat(eo, pe, rom), 2'h0);
    rdChk(8'h10, {24'h0, factoryTrim}, 2'h0);
    @(negedge core_clk);
    chk(vecFetchAddrOut, rom ? (rpb_pkg::ROM_BASE | vecFetchAddr) : vecFetchAddr);
    @(posedge core_clk);
    axiWr(8'h08, 32'h6, r);
    @(negedge core_clk);
    chk(vectorRemap, 1'b0);
    @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] o, eo;
    logic bp, rom;
    int oeBase;
    logic [1:0] r;
    {nrst, sysResetReq, vllsWakeup, flashInitDone, extHold} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    {vllsWakeupViaPin, bootPinInN, optionByte, factoryTrim} = {2'b11, 16'hff00};
    for (int i = 0; i < 8; i++) begin
      o = i < 5 ? TBL[i] : rs[7:0];
      bp = i < 5 ? 1'b1 : rs[9];
      eo = o == 8'h00 ? 8'hff : o;
      rom = eo[7:6] == 2'b11 || (!eo[1] && !bp);
      powerOn(o, bp, eo[3]);
      checkBoot(eo, eo[3], rom);
      extHold <= 1'b1;
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      chk(chipResetN, !eo[3]);
      @(posedge core_clk);
      extHold <= 1'b0;
      waitRun();
    end
    // read-only, unmapped, forced mode, late option change
    powerOn(8'hff, 1'b1, 1'b1);
    axiWr(8'h00, 32'h0, r);
    chk(r, 2'h0);
    rdChk(8'h00, 32'hff, 2'h0);
    rdChk(8'h20, 32'h0, 2'h2);
    axiWr(8'h04, 32'h4, r);
    rdChk(8'h04, 32'h4, 2'h0);
    optionByte <= 8'h23;
    rdChk(8'h00, 32'hff, 2'h0);
    sysResetReq <= 1'b1;
    @(posedge core_clk);
    sysResetReq <= 1'b0;
    bootSeq(1'b1);
    rdChk(8'h04, 32'h0, 2'h0);
    checkBoot(8'h23, 1'b1, 1'b1);
    // wakeup resets without and with the pin
    for (int k = 0; k < 2; k++) begin
      vllsWakeupViaPin <= k[0];
      oeBase = oeCnt;
      vllsWakeup <= 1'b1;
      @(posedge core_clk);
      vllsWakeup <= 1'b0;
      bootSeq(1'b1);
      chk(oeCnt != oeBase, k[0]);
    end
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
